// file: dsb_pkg.sv
// shared constants for the two-word burst memory port, both ends
// assumes one core clock; the memory half-clock phases are a toggle
// How it works
// (R01) write data captured on both clock phases
// (R02) read data driven on both phases
// (R03) outputs released whenever no read runs
// (R04) controller pulls load strobe low per cycle
// (R05) every access moves exactly two words
// (R06) high select reads, low select writes
// (R07) byte masks sampled on each phase
// (R08) masked bytes keep their stored contents
// (R09) address lsb seeds one-bit burst counter
// (R10) one shared address bus, width per variant
// (R11) address ignored while port deselected
// (R12) no separate read and write addresses
// (R13) accesses start on positive phase edge
// (R14) pll off gives two-cycle read latency
// (R15) free-running echo clock follows output phase
// (R16) controller expects first word after latency
package dsb_pkg;
  // ----------------------------------------------------------------
  // geometry
  // ----------------------------------------------------------------
  localparam int DSB_ADDR_W_X18 = 23;
  localparam int DSB_ADDR_W_X36 = 22;
  localparam int DSB_BYTE_W     = 9;
  localparam int DSB_BURST_LEN  = 2;
  // ----------------------------------------------------------------
  // read latency in core cycles (one core cycle is one clock phase)
  // ----------------------------------------------------------------
  localparam int DSB_LAT_PLL_ON  = 3;
  localparam int DSB_LAT_PLL_OFF = 2;
endpackage

// file: dsb_if.sv
// interface joining the memory port end and the controller end
// assumes one driving end per signal; data is split by direction
`timescale 1ns/1ps
`default_nettype none
interface dsb_if #(
  parameter int AW = 22,
  parameter int DW = 36
);
  logic              phase_k;          // high: positive input clock phase
  logic              load_strobe_n;
  logic              rd_wr_sel;
  logic [AW-1:0]     addr;
  logic [DW/dsb_pkg::DSB_BYTE_W-1:0] byte_lane_mask_n;
  logic [DW-1:0]     dq_to_mem;
  logic [DW-1:0]     dq_from_mem;
  logic              dq_mem_oe;
  logic              echo_timing;
  logic              pll_disable_n;

  modport mem (
    input  phase_k, load_strobe_n, rd_wr_sel, addr, byte_lane_mask_n,
    input  dq_to_mem, pll_disable_n,
    output dq_from_mem, dq_mem_oe, echo_timing
  );
  modport ctl (
    output phase_k, load_strobe_n, rd_wr_sel, addr, byte_lane_mask_n,
    output dq_to_mem, pll_disable_n,
    input  dq_from_mem, dq_mem_oe, echo_timing
  );
endinterface
`default_nettype wire

// file: dsb_mem.sv
// memory end: captures commands, stores words, returns read bursts
// assumes controller drives the phase toggle and keeps the protocol
`timescale 1ns/1ps
`default_nettype none
module dsb_mem #(
  parameter int AW = dsb_pkg::DSB_ADDR_W_X36,
  parameter int DW = 36
) (
  input  wire logic i_core_clk,
  input  wire logic i_sys_rst,
  dsb_if.mem        bus
);
  localparam int NB = DW / dsb_pkg::DSB_BYTE_W;
  localparam int WD = 1 << AW;
  localparam int LP = dsb_pkg::DSB_LAT_PLL_ON;  // read shift depth

  // (R10) one shared address bus; the x18 variant, with the most address bits, bounds the depth
  if (DW % dsb_pkg::DSB_BYTE_W != 0 ||
      AW > dsb_pkg::DSB_ADDR_W_X18) begin : g_bad_geom
    $error("unsupported width or depth");
  end

  typedef enum {DSB_IDLE, DSB_WR0, DSB_WR1} dsb_wst_t;

  logic [DW-1:0] mem_q [WD];
  dsb_wst_t      wst_q;
  logic [AW-1:0] waddr_q;
  logic [AW-1:0] raddr_q;
  logic [LP-1:0] rpipe_q;   // read launch shift, one bit per phase
  logic [DW-1:0] dq_q;
  logic          oe_q;
  logic          echo_q;
  logic [AW-1:0] rd_word;

  // ----------------------------------------------------------------
  // write sequencer
  // ----------------------------------------------------------------
  // (R13) start on positive phase; (R11) deselected ignores address
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      wst_q <= DSB_IDLE;
      waddr_q <= '0;
    end else begin
      case (wst_q)
        DSB_IDLE: begin
          // (R06) low select means write
          if (bus.phase_k && !bus.load_strobe_n && !bus.rd_wr_sel) begin
            wst_q   <= DSB_WR0;
            waddr_q <= bus.addr;
          end
        end
        DSB_WR0: wst_q <= DSB_WR1;
        DSB_WR1: wst_q <= DSB_IDLE;
        default: wst_q <= DSB_IDLE;
      endcase
    end
  end

  // (R09) burst counter flips address lsb for second word
  function automatic logic [AW-1:0] dsb_burst_addr(
    input logic [AW-1:0] a, input logic second);
    dsb_burst_addr = {a[AW-1:1], a[0] ^ second};
  endfunction

  // ----------------------------------------------------------------
  // array write, one word per phase
  // ----------------------------------------------------------------
  // (R01) data on both phases; (R07) masks each phase; (R08) keep bytes
  always_ff @(posedge i_core_clk) begin
    if (wst_q == DSB_WR0 || wst_q == DSB_WR1) begin
      for (int b = 0; b < NB; b++) begin
        if (!bus.byte_lane_mask_n[b])
          mem_q[dsb_burst_addr(waddr_q, wst_q == DSB_WR1)]
               [b*dsb_pkg::DSB_BYTE_W +: dsb_pkg::DSB_BYTE_W]
            <= bus.dq_to_mem[b*dsb_pkg::DSB_BYTE_W +: dsb_pkg::DSB_BYTE_W];
      end
    end
  end

  // ----------------------------------------------------------------
  // read pipeline
  // ----------------------------------------------------------------
  // (R14) pll-off shortens latency by one phase
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      rpipe_q <= '0;
      raddr_q <= '0;
    end else begin
      rpipe_q <= {rpipe_q[LP-2:0],
                  bus.phase_k && !bus.load_strobe_n && bus.rd_wr_sel};
      if (bus.phase_k && !bus.load_strobe_n && bus.rd_wr_sel)
        raddr_q <= bus.addr;
    end
  end

  // first word launch bit depends on mode; second follows next phase
  logic first_w;
  logic second_w;
  assign first_w  = bus.pll_disable_n ? rpipe_q[dsb_pkg::DSB_LAT_PLL_ON-2]
                                      : rpipe_q[dsb_pkg::DSB_LAT_PLL_OFF-2];
  assign second_w = bus.pll_disable_n ? rpipe_q[dsb_pkg::DSB_LAT_PLL_ON-1]
                                      : rpipe_q[dsb_pkg::DSB_LAT_PLL_OFF-1];
  assign rd_word  = dsb_burst_addr(raddr_q, second_w);

  // (R02) drive on both phases; (R05) two words; (R03) release otherwise
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      oe_q <= 1'b0;
      dq_q <= '0;
    end else begin
      oe_q <= first_w || second_w;
      dq_q <= (first_w || second_w) ? mem_q[rd_word] : '0;
    end
  end

  // (R15) echo clock free-running, follows the phase
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst)
      echo_q <= 1'b0;
    else
      echo_q <= bus.phase_k;
  end

  assign bus.dq_from_mem = dq_q;
  assign bus.dq_mem_oe   = oe_q;
  assign bus.echo_timing = echo_q;
endmodule
`default_nettype wire

// file: dsb_ctl.sv
// controller end: turns user requests into two-word burst cycles
// assumes user holds request until o_req_ready pulse
`timescale 1ns/1ps
`default_nettype none
module dsb_ctl #(
  parameter int AW = dsb_pkg::DSB_ADDR_W_X36,
  parameter int DW = 36
) (
  input  wire logic           i_core_clk,
  input  wire logic           i_sys_rst,
  input  wire logic           i_req,
  input  wire logic           i_req_rd,
  input  wire logic [AW-1:0]  i_req_addr,
  input  wire logic [2*DW-1:0] i_wr_data,
  input  wire logic [2*DW/dsb_pkg::DSB_BYTE_W-1:0] i_wr_mask_n,
  input  wire logic           i_pll_disable_n,
  output logic                o_req_ready,
  output logic                o_rd_valid,
  output logic [2*DW-1:0]     o_rd_data,
  dsb_if.ctl                  bus
);
  localparam int NB = DW / dsb_pkg::DSB_BYTE_W;

  if (DW % dsb_pkg::DSB_BYTE_W != 0) begin : g_bad_width
    $error("data width must be whole bytes");
  end

  typedef enum {DSC_IDLE, DSC_W0, DSC_W1, DSC_RWAIT} dsb_cst_t;

  dsb_cst_t        st_q;
  logic            ph_q;
  logic            ld_n_q;
  logic            rw_q;
  logic [AW-1:0]   addr_q;
  logic [NB-1:0]   mask_q;
  logic [DW-1:0]   dq_q;
  logic [2*DW-1:0] wbuf_q;
  logic [2*NB-1:0] mbuf_q;
  logic            ready_q;
  logic            rv_q;
  logic [2*DW-1:0] rdat_q;
  logic            got0_q;
  logic [2:0]      pll_sync_q;   // strap pin, three sampling stages
  logic            pll_dis_n_q;  // settled strap level handed to the bus

  // ----------------------------------------------------------------
  // phase toggle, high on the positive input clock phase
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst)
      ph_q <= 1'b0;
    else
      ph_q <= !ph_q;
  end

  // ----------------------------------------------------------------
  // pll strap synchroniser
  // ----------------------------------------------------------------
  // (R14) the strap is a board pin with no clock relation, so a change
  // only counts once the last two stages agree; reset assumes pll on
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      pll_sync_q  <= '1;
      pll_dis_n_q <= 1'b1;
    end else begin
      pll_sync_q <= {pll_sync_q[1:0], i_pll_disable_n};
      if (pll_sync_q[2] == pll_sync_q[1])
        pll_dis_n_q <= pll_sync_q[1];
    end
  end

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  // (R04) strobe low for one positive phase; (R12) one address bus
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      st_q <= DSC_IDLE;
      ld_n_q <= 1'b1;
      rw_q <= 1'b1;
      addr_q <= '0;
      mask_q <= '1;
      dq_q <= '0;
      wbuf_q <= '0;
      mbuf_q <= '1;
      ready_q <= 1'b0;
    end else begin
      ld_n_q  <= 1'b1;
      ready_q <= 1'b0;
      mask_q  <= '1;
      case (st_q)
        DSC_IDLE: begin
          // launch so strobe lands in a positive phase (next ph high)
          if (i_req && !ph_q && !ready_q) begin
            ld_n_q  <= 1'b0;
            rw_q    <= i_req_rd;
            addr_q  <= i_req_addr;
            wbuf_q  <= i_wr_data;
            mbuf_q  <= i_wr_mask_n;
            ready_q <= 1'b1;
            st_q    <= i_req_rd ? DSC_RWAIT : DSC_W0;
          end
        end
        // (R05) two data words per write burst
        DSC_W0: begin
          dq_q   <= wbuf_q[DW-1:0];
          mask_q <= mbuf_q[NB-1:0];
          st_q   <= DSC_W1;
        end
        DSC_W1: begin
          dq_q   <= wbuf_q[2*DW-1:DW];
          mask_q <= mbuf_q[2*NB-1:NB];
          st_q   <= DSC_IDLE;
        end
        DSC_RWAIT: begin
          if (o_rd_valid)
            st_q <= DSC_IDLE;
        end
        default: st_q <= DSC_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read capture while the memory drives
  // ----------------------------------------------------------------
  // (R16) words arrive after the mode latency, flagged by the enable
  always_ff @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      got0_q <= 1'b0;
      rv_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      rv_q <= 1'b0;
      if (st_q == DSC_RWAIT && bus.dq_mem_oe) begin
        if (!got0_q) begin
          rdat_q[DW-1:0] <= bus.dq_from_mem;
          got0_q <= 1'b1;
        end else begin
          rdat_q[2*DW-1:DW] <= bus.dq_from_mem;
          got0_q <= 1'b0;
          rv_q <= 1'b1;
        end
      end
    end
  end

  assign bus.phase_k          = ph_q;
  assign bus.load_strobe_n    = ld_n_q;
  assign bus.rd_wr_sel        = rw_q;
  assign bus.addr             = addr_q;
  assign bus.byte_lane_mask_n = mask_q;
  assign bus.dq_to_mem        = dq_q;
  assign bus.pll_disable_n    = pll_dis_n_q;
  assign o_req_ready          = ready_q;
  assign o_rd_valid           = rv_q;
  assign o_rd_data            = rdat_q;
endmodule
`default_nettype wire

// file: dsb_chk.sv
// checker on the signals between the memory end and the controller end
// assumes one core clock and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module dsb_chk #(
  parameter int DW = 36
) (
  input wire logic          i_core_clk,
  input wire logic          i_sys_rst,
  input wire logic          phase_k,
  input wire logic          load_strobe_n,
  input wire logic          rd_wr_sel,
  input wire logic [DW-1:0] dq_from_mem,
  input wire logic          dq_mem_oe,
  input wire logic          echo_timing,
  input wire logic          pll_disable_n
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);
  logic rd_ld;
  logic wr_ld;
  // decoded loads, kept as nets so $past sees plain signals
  assign rd_ld = !load_strobe_n && rd_wr_sel;
  assign wr_ld = !load_strobe_n && !rd_wr_sel;
  // ----------------------------------------------------------------
  // read burst shape and the other bus protocol checks
  // ----------------------------------------------------------------
  sequence s_burst;
    dq_mem_oe ##1 dq_mem_oe ##1 !dq_mem_oe;
  endsequence
  a_load_phase: assert property (!load_strobe_n |-> phase_k)
    else $error("load outside positive phase");
  a_load_single: assert property (!load_strobe_n |=> load_strobe_n[*2])
    else $error("load strobe too long or too close");
  a_read_pll_on: assert property (rd_ld && pll_disable_n |-> ##3 s_burst)
    else $error("read burst late or wrong length, pll on");
  a_read_pll_off: assert property (rd_ld && !pll_disable_n |-> ##2 s_burst)
    else $error("read burst late or wrong length, pll off");
  a_oe_cause: assert property ($rose(dq_mem_oe) |->
    (pll_disable_n ? $past(rd_ld, 3) : $past(rd_ld, 2)))
    else $error("data output enabled without a read");
  a_release_quiet: assert property (!dq_mem_oe |-> dq_from_mem == '0)
    else $error("read data while released");
  a_write_quiet: assert property (wr_ld |-> !dq_mem_oe[*4])
    else $error("output enabled during a write");
  a_echo_phase: assert property (!$past(i_sys_rst) |->
    echo_timing == $past(phase_k))
    else $error("echo clock not one cycle behind phase");
endmodule
`default_nettype wire

// file: tb_ddr_sram_two_word_burst_port.sv
// bench: controller end and memory end joined through the interface
// assumes the hand-over timing: ready pulse, valid after read burst
`timescale 1ns/1ps
`default_nettype none
module tb_ddr_sram_two_word_burst_port;
  localparam int AW = 22;
  localparam int DW = 36;
  localparam int NB = DW / 9;
  localparam logic [AW-1:0] AL = 22'h012344;
  localparam logic [AW-1:0] AT = 22'h3ffffe;
  localparam logic [2*DW-1:0] D0 = 72'h0f1e2d3c4b5a697887;
  localparam logic [2*DW-1:0] D1 = 72'ha5c3961e87b4d2f01c;
  logic            i_core_clk;
  logic            i_sys_rst;
  logic            i_req;
  logic            i_req_rd;
  logic [AW-1:0]   i_req_addr;
  logic [2*DW-1:0] i_wr_data;
  logic [2*NB-1:0] i_wr_mask_n;
  logic            i_pll_disable_n;
  logic            o_req_ready;
  logic            o_rd_valid;
  logic [2*DW-1:0] o_rd_data;
  logic [DW-1:0]   ref_q [logic [AW-1:0]];
  int              fail_count;
  int              total_checks;
  dsb_if #(.AW(AW), .DW(DW)) bus ();
  dsb_mem #(.AW(AW), .DW(DW)) dsb_mem_i (.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .bus(bus));
  dsb_ctl #(.AW(AW), .DW(DW)) dsb_ctl_i (.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .i_req(i_req), .i_req_rd(i_req_rd),
    .i_req_addr(i_req_addr), .i_wr_data(i_wr_data),
    .i_wr_mask_n(i_wr_mask_n), .i_pll_disable_n(i_pll_disable_n),
    .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data), .bus(bus));
  dsb_chk #(.DW(DW)) dsb_chk_i (.i_core_clk(i_core_clk),
    .i_sys_rst(i_sys_rst), .phase_k(bus.phase_k),
    .load_strobe_n(bus.load_strobe_n), .rd_wr_sel(bus.rd_wr_sel),
    .dq_from_mem(bus.dq_from_mem), .dq_mem_oe(bus.dq_mem_oe),
    .echo_timing(bus.echo_timing), .pll_disable_n(bus.pll_disable_n));
  // 100 MHz core clock
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge i_core_clk);
    #1;
  endtask
  task automatic chk(input logic [2*DW-1:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // hold the request until the ready pulse; bounded wait
  task automatic req(input logic rd, input logic [AW-1:0] a,
      input logic [2*DW-1:0] d, input logic [2*NB-1:0] m);
    int n;
    i_req = 1'b1;
    i_req_rd = rd;
    i_req_addr = a;
    i_wr_data = d;
    i_wr_mask_n = m;
    n = 0;
    do begin
      cyc(1);
      n++;
    end while (o_req_ready !== 1'b1 && n < 50);
    chk_bit(o_req_ready, 1'b1);
    // keep the request up across the edge that samples ready
    cyc(1);
    chk_bit(o_req_ready, 1'b0);
    i_req = 1'b0;
  endtask
  // second word lands at the partner address, lsb flipped
  task automatic wr(input logic [AW-1:0] a, input logic [2*DW-1:0] d,
      input logic [2*NB-1:0] m);
    req(1'b0, a, d, m);
    for (int k = 0; k < 2; k++) begin
      for (int b = 0; b < NB; b++) begin
        if (!m[k*NB+b]) ref_q[a^AW'(k)][b*9+:9] = d[k*DW+b*9+:9];
      end
    end
    cyc(4);
  endtask
  task automatic rdchk(input logic [AW-1:0] a);
    int n;
    req(1'b1, a, '0, '1);
    n = 0;
    while (o_rd_valid !== 1'b1 && n < 50) begin
      cyc(1);
      n++;
    end
    chk_bit(o_rd_valid, 1'b1);
    chk(o_rd_data, {ref_q[a^AW'(1)], ref_q[a]});
    cyc(1);
    chk_bit(o_rd_valid, 1'b0);
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests: same sequence with pll on, then pll off
  // ----------------------------------------------------------------
  initial begin
    fail_count = 0;
    total_checks = 0;
    i_sys_rst = 1'b1;
    i_req = 1'b0;
    i_req_rd = 1'b0;
    i_req_addr = '0;
    i_wr_data = '0;
    i_wr_mask_n = '1;
    i_pll_disable_n = 1'b1;
    cyc(8);
    i_sys_rst = 1'b0;
    cyc(2);
    for (int p = 1; p >= 0; p--) begin
      i_pll_disable_n = p[0];
      cyc(2);
      wr(AL, D0, 8'h00);
      rdchk(AL);
      wr(AL, D1, 8'h5a);
      rdchk(AL);
      wr(AL | 22'h1, D1, 8'h00);
      rdchk(AL);
      wr(AT, D0, 8'h00);
      rdchk(AL);
      rdchk(AT);
      $display("test pll_on=%0d done", p);
    end
    tally_and_finish();
  end
  // watchdog far beyond the fewer than 200 cycles the tests need
  initial begin
    #50000;
    fail_count++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
